// File: design/mrf_pkg.sv
/*
 * Package for the reservation fallback and channel allocation link.
 * Holds PDU type codes, allocation type codes, field widths, timer
 * defaults and the state enumerations shared by both ends.
 * Assumes both ends run on one clock and one asynchronous reset.
 */
// How it works
// - Fall back only when all four conditions hold
// - Timer restarts on own PDU or wait-grant
// - Fallback request goes out as access PDU
// - Access PDU asks reservation if more queued
// - Reversion timeout never below fragmentation timeout
// - Timer counts downlink signalling opportunities only
// - Cancel with handle stops matching request at once
// - Cancel reports abort, partial or fully sent
// - Cancel after first access stops all retries
// - Allocation is optional element of resource/end PDU
// - Fragmented message carries allocation only in end
// - End allocation applies to first-fragment addressees
// - Assigned channel uses timeslot bit map
// - All-zero timeslots plus main carrier means common
// - Cell-change flag: bitmap uses new cell numbering
// - Single-channel station stays-reject or moves-accept
// - Two-bit allocation type selects channel action; code treats only Add apart, the other three types all load the allocation
package mrf_pkg;

	// ************************************************************
	// Field widths
	// ************************************************************
	localparam int MRF_ADDR_W    = 24; // Station address width
	localparam int MRF_HANDLE_W  = 8;  // Request handle width
	localparam int MRF_TS_W      = 4;  // Timeslot bit map width
	localparam int MRF_CARR_W    = 12; // Carrier number width
	localparam int MRF_TMR_W     = 16; // Reversion counter width

	// ************************************************************
	// Timing defaults, in downlink signalling opportunities
	// ************************************************************
	localparam logic [15:0] MRF_REVERT_DEF = 16'h0010; // Reversion
	localparam logic [15:0] MRF_FRAG_DEF   = 16'h0008; // Fragmentation
	localparam int          MRF_MIN_MODE_FACTOR = 18;  // Info only

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [3:0] MRF_TS_RST = 4'h0; // Common channel

	// ************************************************************
	// PDU kinds on the link
	// ************************************************************
	typedef enum logic [2:0] {
		MRF_PDU_NONE   = 3'b000,
		MRF_PDU_ACCESS = 3'b001, // Random access, uplink half slot
		MRF_PDU_DATA   = 3'b010, // Reserved uplink data
		MRF_PDU_FRAG   = 3'b011, // Uplink continuation
		MRF_PDU_END    = 3'b100, // Last fragment, either way
		MRF_PDU_RES    = 3'b101  // Downlink resource
	} mrf_pdu_type;

	// ************************************************************
	// Allocation type codes
	// ************************************************************
	typedef enum logic [1:0] {
		MRF_AT_REPLACE = 2'b00,
		MRF_AT_ADD     = 2'b01,
		MRF_AT_QUIT    = 2'b10,
		MRF_AT_REP_TS1 = 2'b11
	} mrf_alloc_type;

	// ************************************************************
	// Abort report codes
	// ************************************************************
	typedef enum logic [1:0] {
		MRF_RPT_NONE    = 2'b00,
		MRF_RPT_PARTIAL = 2'b01, // Not completely sent
		MRF_RPT_SENT    = 2'b10  // Sent completely at least once
	} mrf_rpt_type;

	// ************************************************************
	// Station states
	// ************************************************************
	typedef enum logic [1:0] {
		MRF_ST_IDLE = 2'b00, // Nothing pending
		MRF_ST_WAIT = 2'b01, // Reservation asked, waiting grant
		MRF_ST_RAND = 2'b10  // Random access retries allowed
	} mrf_state_type;

endpackage

// File: design/mrf_link_if.sv
/*
 * Link between the station and base station medium-access ends.
 * One word-wide PDU channel each way, valid for one cycle per PDU.
 * Assumes one shared clock; no wire is two-way.
 */
`timescale 1ns/10ps
`default_nettype none
interface mrf_link_if;
	import mrf_pkg::*;

	// Uplink: station to base station
	logic        ul_valid;    // One-cycle PDU strobe
	mrf_pdu_type ul_pdu;      // PDU kind
	logic [23:0] ul_addr;     // Sending station address
	logic        ul_resreq;   // Reservation requirement present
	logic        ul_has_sdu;  // Carries service data

	// Downlink: base station to station
	logic        dl_opp;      // Downlink signalling opportunity
	logic        dl_valid;    // One-cycle PDU strobe
	mrf_pdu_type dl_pdu;      // RES or END
	logic [23:0] dl_addr;     // Addressee
	logic        dl_grant;    // Slot grant element present
	logic        dl_wait;     // Grant says wait for another
	logic        dl_ca_valid; // Channel allocation element present
	mrf_alloc_type dl_ca_type; // Allocation type
	logic [3:0]  dl_ca_ts;    // Timeslot bit map
	logic [11:0] dl_ca_carr;  // Carrier number
	logic        dl_ca_cell;  // Cell change flag

	modport station (
		output ul_valid, ul_pdu, ul_addr, ul_resreq, ul_has_sdu,
		input  dl_opp, dl_valid, dl_pdu, dl_addr, dl_grant, dl_wait,
		input  dl_ca_valid, dl_ca_type, dl_ca_ts, dl_ca_carr, dl_ca_cell
	);
	modport base (
		input  ul_valid, ul_pdu, ul_addr, ul_resreq, ul_has_sdu,
		output dl_opp, dl_valid, dl_pdu, dl_addr, dl_grant, dl_wait,
		output dl_ca_valid, dl_ca_type, dl_ca_ts, dl_ca_carr, dl_ca_cell
	);
endinterface
`default_nettype wire

// File: design/mrf_station.sv
/*
 * Station end: reversion timer, fallback to random access, cancel
 * handling and channel allocation reception.
 * Assumes the upper layer holds request inputs steady and the base
 * station end keeps its own placement and coding duties.
 */
`timescale 1ns/10ps
`default_nettype none
module mrf_station
	import mrf_pkg::*;
#(
	parameter logic [15:0] REVERT_OPPS = MRF_REVERT_DEF,
	parameter logic [15:0] FRAG_OPPS   = MRF_FRAG_DEF
) (
	// Clock and reset
	input  wire logic               I_REF_CLK,
	input  wire logic               I_RST_B,
	// Link
	mrf_link_if.station             link,
	// Upper layer request
	input  wire logic [23:0]        I_ADDR,
	input  wire logic               I_DATA_IN_BUF,
	input  wire logic               I_MORE_QUEUED,
	input  wire logic [7:0]         I_REQ_HANDLE,
	input  wire logic               I_SEND_RES,
	input  wire logic               I_CANCEL,
	input  wire logic [7:0]         I_CANCEL_HANDLE,
	input  wire logic               I_CONCURRENT_OK,
	input  wire logic               I_ACCEPT_ADD,
	// Upper layer report
	output logic                    O_RPT_VALID,
	output mrf_rpt_type             O_RPT_KIND,
	output logic [7:0]              O_RPT_HANDLE,
	output logic                    O_REVERT_EXP,
	// Channel state
	output logic [3:0]              O_CHAN_TS,
	output logic [11:0]             O_CHAN_CARR,
	output logic                    O_CHAN_COMMON,
	output logic                    O_CHAN_NEWCELL,
	output logic                    O_ADD_REJECT
);

	// ************************************************************
	// State
	// ************************************************************
	mrf_state_type st_reg, st_next;           // Request state
	logic [15:0] tmr_reg, tmr_next;           // Opportunities elapsed
	logic        granted_reg, granted_next;   // Capacity held
	logic        sent_once_reg, sent_once_next; // Whole SDU sent
	logic        ul_v_reg, ul_v_next;
	mrf_pdu_type ul_p_reg, ul_p_next;
	logic        ul_rr_reg, ul_rr_next;
	logic        ul_sdu_reg, ul_sdu_next;
	logic        rpt_v_reg, rpt_v_next;
	mrf_rpt_type rpt_k_reg, rpt_k_next;
	logic [7:0]  rpt_h_reg, rpt_h_next;
	logic [3:0]  ts_reg, ts_next;
	logic [11:0] carr_reg, carr_next;
	logic        cell_reg, cell_next;
	logic        rej_reg, rej_next;
	logic        exp_w;                       // Timer expired
	logic        rx_me;                       // Downlink for me
	logic        rexp_reg, rexp_next;         // Expiry shown upward
	logic        com_reg, com_next;           // On a common channel
	// An end PDU arrives unaddressed, so keep whether the resource
	// PDU of the first fragment was addressed to this station.
	logic        frag_me_reg, frag_me_next;
	// Longer of the two timeouts: reverting never cuts a fragment
	localparam logic [15:0] EFF_OPPS = (REVERT_OPPS < FRAG_OPPS) ?
		FRAG_OPPS : REVERT_OPPS;

	// Expiry once count reaches setting; setting clamped so it is
	// never below the fragmentation timeout.
	assign exp_w = tmr_reg >= EFF_OPPS;
	// End PDU follows first-fragment addressees
	assign rx_me = link.dl_valid && ((link.dl_pdu == MRF_PDU_END) ?
		frag_me_reg : (link.dl_addr == I_ADDR));

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		st_next = st_reg;
		tmr_next = tmr_reg;
		granted_next = granted_reg;
		sent_once_next = sent_once_reg;
		ul_v_next = 1'b0;
		ul_p_next = MRF_PDU_NONE;
		ul_rr_next = 1'b0;
		ul_sdu_next = 1'b0;
		rpt_v_next = 1'b0;
		rpt_k_next = rpt_k_reg;
		rpt_h_next = rpt_h_reg;
		ts_next = ts_reg;
		carr_next = carr_reg;
		cell_next = cell_reg;
		rej_next = 1'b0;
		frag_me_next = frag_me_reg;
		// Count downlink opportunities, not time
		if (link.dl_opp && !exp_w) begin
			tmr_next = tmr_reg + 16'h0001;
		end
		// Track first-fragment addressees
		if (link.dl_valid && link.dl_pdu == MRF_PDU_RES) begin
			frag_me_next = (link.dl_addr == I_ADDR);
		end
		// Grant handling; wait instruction restarts the timer
		if (rx_me && link.dl_grant) begin
			if (link.dl_wait) begin
				tmr_next = 16'h0000;
				granted_next = 1'b0;
			end else begin
				granted_next = 1'b1;
			end
		end
		case (st_reg)
			MRF_ST_IDLE: begin
				// Reserved-access PDU asks for capacity
				if (I_SEND_RES) begin
					ul_v_next = 1'b1;
					ul_p_next = MRF_PDU_DATA;
					ul_rr_next = 1'b1;
					ul_sdu_next = 1'b1;
					tmr_next = 16'h0000;
					// A grant landing now is kept: set wins over clear
					granted_next = rx_me && link.dl_grant &&
						!link.dl_wait;
					sent_once_next = 1'b0;
					st_next = MRF_ST_WAIT;
				end
			end
			MRF_ST_WAIT: begin
				// All four conditions before falling back
				if (!granted_reg && exp_w && I_DATA_IN_BUF) begin
					ul_v_next = 1'b1;
					ul_p_next = MRF_PDU_ACCESS;
					ul_sdu_next = 1'b1;
					ul_rr_next = I_MORE_QUEUED;
					tmr_next = 16'h0000;
					sent_once_next = 1'b1;
					st_next = MRF_ST_RAND;
				end else if (!I_DATA_IN_BUF) begin
					st_next = MRF_ST_IDLE;
				end
			end
			MRF_ST_RAND: begin
				// Retry access while still queued and ungranted
				if (!I_DATA_IN_BUF) begin
					st_next = MRF_ST_IDLE;
				end else if (!granted_reg && exp_w) begin
					ul_v_next = 1'b1;
					ul_p_next = MRF_PDU_ACCESS;
					ul_sdu_next = 1'b1;
					ul_rr_next = I_MORE_QUEUED;
					tmr_next = 16'h0000;
				end
			end
			default: begin
				st_next = MRF_ST_IDLE;
			end
		endcase
		// Cancel wins over everything for the matching request
		if (I_CANCEL && st_reg != MRF_ST_IDLE &&
			I_CANCEL_HANDLE == I_REQ_HANDLE) begin
			st_next = MRF_ST_IDLE;
			ul_v_next = 1'b0;
			ul_p_next = MRF_PDU_NONE;
			ul_rr_next = 1'b0;
			ul_sdu_next = 1'b0;
			rpt_v_next = 1'b1;
			rpt_h_next = I_CANCEL_HANDLE;
			rpt_k_next = sent_once_reg ? MRF_RPT_SENT :
				MRF_RPT_PARTIAL;
		end
		// Channel allocation reception
		if (rx_me && link.dl_ca_valid) begin
			if (link.dl_ca_type == MRF_AT_ADD && !I_CONCURRENT_OK &&
				!I_ACCEPT_ADD) begin
				rej_next = 1'b1;
			end else begin
				ts_next = link.dl_ca_ts;
				carr_next = link.dl_ca_carr;
				cell_next = link.dl_ca_cell;
			end
		end
		// Registered views of expiry and common channel
		rexp_next = (tmr_next >= EFF_OPPS) && (st_next != MRF_ST_IDLE);
		com_next = (ts_next == MRF_TS_RST);
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			st_reg <= MRF_ST_IDLE;
			tmr_reg <= 16'h0000;
			granted_reg <= 1'b0;
			sent_once_reg <= 1'b0;
			ul_v_reg <= 1'b0;
			ul_p_reg <= MRF_PDU_NONE;
			ul_rr_reg <= 1'b0;
			ul_sdu_reg <= 1'b0;
			rpt_v_reg <= 1'b0;
			rpt_k_reg <= MRF_RPT_NONE;
			rpt_h_reg <= 8'h00;
			ts_reg <= MRF_TS_RST;
			carr_reg <= 12'h000;
			cell_reg <= 1'b0;
			rej_reg <= 1'b0;
			rexp_reg <= 1'b0;
			com_reg <= 1'b1;
			frag_me_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			tmr_reg <= tmr_next;
			granted_reg <= granted_next;
			sent_once_reg <= sent_once_next;
			ul_v_reg <= ul_v_next;
			ul_p_reg <= ul_p_next;
			ul_rr_reg <= ul_rr_next;
			ul_sdu_reg <= ul_sdu_next;
			rpt_v_reg <= rpt_v_next;
			rpt_k_reg <= rpt_k_next;
			rpt_h_reg <= rpt_h_next;
			ts_reg <= ts_next;
			carr_reg <= carr_next;
			cell_reg <= cell_next;
			rej_reg <= rej_next;
			rexp_reg <= rexp_next;
			com_reg <= com_next;
			frag_me_reg <= frag_me_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign link.ul_valid = ul_v_reg;
	assign link.ul_pdu = ul_p_reg;
	assign link.ul_addr = I_ADDR;
	assign link.ul_resreq = ul_rr_reg;
	assign link.ul_has_sdu = ul_sdu_reg;
	assign O_RPT_VALID = rpt_v_reg;
	assign O_RPT_KIND = rpt_k_reg;
	assign O_RPT_HANDLE = rpt_h_reg;
	assign O_REVERT_EXP = rexp_reg;
	assign O_CHAN_TS = ts_reg;
	assign O_CHAN_CARR = carr_reg;
	assign O_CHAN_COMMON = com_reg;
	assign O_CHAN_NEWCELL = cell_reg;
	assign O_ADD_REJECT = rej_reg;

endmodule
`default_nettype wire

// File: design/mrf_base.sv
/*
 * Base station end: issues downlink opportunities, grants and
 * channel allocations, placing the allocation per fragmentation.
 * Assumes user requests are single-cycle strobes.
 */
`timescale 1ns/10ps
`default_nettype none
module mrf_base
	import mrf_pkg::*;
(
	// Clock and reset
	input  wire logic               I_REF_CLK,
	input  wire logic               I_RST_B,
	// Link
	mrf_link_if.base                link,
	// User side
	input  wire logic               I_OPP,
	input  wire logic               I_SEND,
	input  wire logic               I_FRAGMENTED,
	input  wire logic [23:0]        I_ADDR,
	input  wire logic               I_GRANT,
	input  wire logic               I_WAIT,
	input  wire logic               I_CA_REQ,
	input  wire mrf_alloc_type      I_CA_TYPE,
	input  wire logic               I_CA_COMMON,
	input  wire logic [3:0]         I_CA_TS,
	input  wire logic [11:0]        I_CA_CARR,
	input  wire logic               I_CA_CELL,
	output logic                    O_UL_SEEN,
	output logic                    O_UL_RESREQ
);

	// ************************************************************
	// State
	// ************************************************************
	logic        frag_reg;     // Second PDU of fragmented message due
	logic        frag_next;
	logic        opp_reg, v_reg, g_reg, w_reg, cav_reg;
	mrf_pdu_type pdu_reg;
	logic [23:0] addr_reg;
	mrf_alloc_type cat_reg;
	logic [3:0]  ts_reg;
	logic [11:0] carr_reg;
	logic        cell_reg, seen_reg, rr_reg;
	logic        send_w, ca_w;
	mrf_pdu_type pdu_w;

	// Fragmented message: resource first, then end with allocation
	always_comb begin
		send_w = I_SEND || frag_reg;
		pdu_w = frag_reg ? MRF_PDU_END : MRF_PDU_RES;
		ca_w = I_CA_REQ && (frag_reg || !I_FRAGMENTED);
		frag_next = I_SEND && I_FRAGMENTED && !frag_reg;
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			frag_reg <= 1'b0;
			opp_reg <= 1'b0;
			v_reg <= 1'b0;
			g_reg <= 1'b0;
			w_reg <= 1'b0;
			cav_reg <= 1'b0;
			pdu_reg <= MRF_PDU_NONE;
			addr_reg <= 24'h000000;
			cat_reg <= MRF_AT_REPLACE;
			ts_reg <= MRF_TS_RST;
			carr_reg <= 12'h000;
			cell_reg <= 1'b0;
			seen_reg <= 1'b0;
			rr_reg <= 1'b0;
		end else begin
			frag_reg <= frag_next;
			opp_reg <= I_OPP;
			v_reg <= send_w;
			pdu_reg <= send_w ? pdu_w : MRF_PDU_NONE;
			addr_reg <= I_ADDR;
			g_reg <= send_w && I_GRANT;
			w_reg <= send_w && I_GRANT && I_WAIT;
			cav_reg <= send_w && ca_w;
			cat_reg <= I_CA_TYPE;
			// Common channel: zero bit map, main carrier given
			ts_reg <= I_CA_COMMON ? MRF_TS_RST : I_CA_TS;
			carr_reg <= I_CA_CARR;
			cell_reg <= I_CA_CELL;
			seen_reg <= link.ul_valid;
			rr_reg <= link.ul_valid && link.ul_resreq;
		end
	end

	assign link.dl_opp = opp_reg;
	assign link.dl_valid = v_reg;
	assign link.dl_pdu = pdu_reg;
	assign link.dl_addr = addr_reg;
	assign link.dl_grant = g_reg;
	assign link.dl_wait = w_reg;
	assign link.dl_ca_valid = cav_reg;
	assign link.dl_ca_type = cat_reg;
	assign link.dl_ca_ts = ts_reg;
	assign link.dl_ca_carr = carr_reg;
	assign link.dl_ca_cell = cell_reg;
	assign O_UL_SEEN = seen_reg;
	assign O_UL_RESREQ = rr_reg;

endmodule
`default_nettype wire

// File: verification/mrf_link_sva.sv
/*
 * Checker for the link between the station and base station ends.
 * Assumes one clock and the active-low asynchronous reset of both.
 */
`timescale 1ns/10ps
`default_nettype none
module mrf_link_sva
	import mrf_pkg::*;
#(
	parameter logic [15:0] REVERT_OPPS = MRF_REVERT_DEF,
	parameter logic [15:0] FRAG_OPPS   = MRF_FRAG_DEF
) (
	// Clock and reset
	input  wire logic          I_REF_CLK,
	input  wire logic          I_RST_B,
	// Uplink
	input  wire logic          ul_valid,
	input  wire mrf_pdu_type   ul_pdu,
	input  wire logic          ul_resreq,
	// Downlink
	input  wire logic          dl_opp,
	input  wire logic          dl_valid,
	input  wire mrf_pdu_type   dl_pdu,
	input  wire logic          dl_grant,
	input  wire logic          dl_wait,
	input  wire logic          dl_ca_valid,
	input  wire mrf_alloc_type dl_ca_type
);
	// ****
	// Opportunity count since the last restart event
	// ****
	logic [15:0] opp_cnt_reg;  // Opportunities seen
	logic [15:0] opp_cnt_next; // Next count
	logic [15:0] eff_opps;     // Longer of the two timeouts

	assign eff_opps = (REVERT_OPPS > FRAG_OPPS) ? REVERT_OPPS : FRAG_OPPS;

	// Restart on any uplink PDU or a wait grant; saturate, never wrap
	always_comb begin
		opp_cnt_next = opp_cnt_reg;
		if (ul_valid || (dl_valid && dl_grant && dl_wait)) begin
			opp_cnt_next = 16'h0000;
		end else if (dl_opp && opp_cnt_reg != 16'hffff) begin
			opp_cnt_next = opp_cnt_reg + 16'h0001;
		end
	end

	// Register only
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			opp_cnt_reg <= 16'h0000;
		end else begin
			opp_cnt_reg <= opp_cnt_next;
		end
	end

	// ****
	// Properties
	// ****
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_B);

	a_ul_kind: assert property (
		ul_valid |-> ul_pdu inside {MRF_PDU_ACCESS, MRF_PDU_DATA})
		else $error("uplink pdu of wrong kind");
	a_ul_pulse: assert property (ul_valid |=> !ul_valid)
		else $error("uplink strobe longer than one cycle");
	a_data_resreq: assert property (
		ul_valid && ul_pdu == MRF_PDU_DATA |-> ul_resreq)
		else $error("reserved pdu without reservation need");
	a_revert_wait: assert property (
		ul_valid && ul_pdu == MRF_PDU_ACCESS |-> opp_cnt_reg >= eff_opps)
		else $error("access sent before reversion time");
	a_dl_kind: assert property (
		dl_valid |-> dl_pdu inside {MRF_PDU_RES, MRF_PDU_END})
		else $error("downlink pdu of wrong kind");
	a_ca_inside: assert property (dl_ca_valid |-> dl_valid)
		else $error("allocation outside a pdu");
	a_ca_end_only: assert property (
		dl_valid && dl_pdu == MRF_PDU_RES && dl_ca_valid
		|=> !(dl_valid && dl_pdu == MRF_PDU_END))
		else $error("allocation in opening pdu of fragmented message");
	a_end_follows: assert property (
		dl_valid && dl_pdu == MRF_PDU_END
		|-> $past(dl_valid) && $past(dl_pdu) == MRF_PDU_RES)
		else $error("closing pdu without opening pdu");
	a_wait_grant: assert property (dl_valid && dl_wait |-> dl_grant)
		else $error("wait instruction without grant");

	c_access: cover property (ul_valid && ul_pdu == MRF_PDU_ACCESS);
	c_end_ca: cover property (dl_valid && dl_pdu == MRF_PDU_END && dl_ca_valid);
	c_add: cover property (dl_ca_valid && dl_ca_type == MRF_AT_ADD);
endmodule
`default_nettype wire

// File: verification/mac_reservation_fallback_chan_alloc_test.sv
/*
 * Testbench: station and base station ends joined by the link.
 * Assumes the package, interface and both ends from the design folder.
 */
`timescale 1ns/10ps
`default_nettype none
module mac_reservation_fallback_chan_alloc_test;
	import mrf_pkg::*;
	// ****
	// Signals
	// ****
	localparam logic [15:0] REV   = 16'h0004; // Below frag: clamp applies
	localparam logic [15:0] FRG   = 16'h0006;
	localparam int          EFF   = 6;        // Effective reversion
	localparam logic [23:0] STN   = 24'h00a1b2;
	localparam logic [7:0]  REQ_H = 8'h3c;
	logic          clk, rst_b, buf_q, more_q, send_res, cancel, conc_ok;
	logic          acc_add, opp, send, frag, grant, wt, ca_req, ca_com;
	logic          ca_cell, rpt_v, rev_exp, ch_com, ch_cell, add_rej;
	logic          ul_seen, ul_rr, ul_r, ul_s, seen_r;
	logic [7:0]    cancel_h, rpt_h, rh;
	logic [23:0]   b_addr;
	logic [3:0]    ca_ts, ch_ts;
	logic [11:0]   ca_carr, ch_carr;
	mrf_alloc_type ca_type;
	mrf_rpt_type   rpt_k, rk;
	mrf_pdu_type   ul_k;
	int            err_count, checks_done, ul_n, seen_n, rpt_n, rej_n;

	mrf_link_if lnk ();
	mrf_station #(.REVERT_OPPS(REV), .FRAG_OPPS(FRG)) mrf_station_inst (
		.I_REF_CLK(clk), .I_RST_B(rst_b), .link(lnk), .I_ADDR(STN),
		.I_DATA_IN_BUF(buf_q), .I_MORE_QUEUED(more_q),
		.I_REQ_HANDLE(REQ_H), .I_SEND_RES(send_res), .I_CANCEL(cancel),
		.I_CANCEL_HANDLE(cancel_h), .I_CONCURRENT_OK(conc_ok),
		.I_ACCEPT_ADD(acc_add), .O_RPT_VALID(rpt_v), .O_RPT_KIND(rpt_k),
		.O_RPT_HANDLE(rpt_h), .O_REVERT_EXP(rev_exp), .O_CHAN_TS(ch_ts),
		.O_CHAN_CARR(ch_carr), .O_CHAN_COMMON(ch_com),
		.O_CHAN_NEWCELL(ch_cell), .O_ADD_REJECT(add_rej));
	mrf_base mrf_base_inst (
		.I_REF_CLK(clk), .I_RST_B(rst_b), .link(lnk), .I_OPP(opp),
		.I_SEND(send), .I_FRAGMENTED(frag), .I_ADDR(b_addr),
		.I_GRANT(grant), .I_WAIT(wt), .I_CA_REQ(ca_req),
		.I_CA_TYPE(ca_type), .I_CA_COMMON(ca_com), .I_CA_TS(ca_ts),
		.I_CA_CARR(ca_carr), .I_CA_CELL(ca_cell), .O_UL_SEEN(ul_seen),
		.O_UL_RESREQ(ul_rr));
	mrf_link_sva #(.REVERT_OPPS(REV), .FRAG_OPPS(FRG)) mrf_link_sva_inst (
		.I_REF_CLK(clk), .I_RST_B(rst_b), .ul_valid(lnk.ul_valid),
		.ul_pdu(lnk.ul_pdu), .ul_resreq(lnk.ul_resreq),
		.dl_opp(lnk.dl_opp), .dl_valid(lnk.dl_valid),
		.dl_pdu(lnk.dl_pdu), .dl_grant(lnk.dl_grant),
		.dl_wait(lnk.dl_wait), .dl_ca_valid(lnk.dl_ca_valid),
		.dl_ca_type(lnk.dl_ca_type));

	// ****
	// Clock, monitor and shared tasks
	// ****
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Count one-cycle pulses at the falling edge, half a cycle after
	// the registers moved, so no read races the launching edge
	always @(negedge clk) begin
		if (lnk.ul_valid === 1'b1) begin
			ul_n++;
			ul_k = lnk.ul_pdu;
			ul_r = lnk.ul_resreq;
			ul_s = lnk.ul_has_sdu;
		end
		if (ul_seen === 1'b1) begin
			seen_n++;
			seen_r = ul_rr;
		end
		if (rpt_v === 1'b1) begin
			rpt_n++;
			rk = rpt_k;
			rh = rpt_h;
		end
		if (add_rej === 1'b1)
			rej_n++;
	end

	task check(input string what, input logic [31:0] seen, want);
		checks_done++;
		if (seen !== want) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask

	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Opportunities are spaced so no two land near one uplink PDU
	task opps(input int n);
		repeat (n) begin
			opp = 1'b1;
			step(1);
			opp = 1'b0;
			step(4);
		end
	endtask

	task pulse_res;
		send_res = 1'b1;
		step(1);
		send_res = 0;
		step(2);
		check("reserved kind", ul_k, MRF_PDU_DATA);
		check("reserved need", ul_r, 1'b1);
	endtask

	task do_cancel(input logic [7:0] h, input int n, input mrf_rpt_type k);
		int r0;
		r0 = rpt_n;
		cancel_h = h;
		cancel = 1'b1;
		step(1);
		cancel = 1'b0;
		step(2);
		check("report count", rpt_n - r0, n);
		if (n > 0) begin
			check("report kind", rk, k);
			check("report handle", rh, h);
		end
	endtask

	// Sends one downlink message, judging allocation placement on the wire
	task pulse_send(input logic fr);
		frag = fr;
		send = 1'b1;
		step(1);
		send = 1'b0;
		if (fr) begin
			check("opening ca", lnk.dl_ca_valid, 1'b0);
			step(1);
			check("closing kind", lnk.dl_pdu, MRF_PDU_END);
		end
		check("ca present", lnk.dl_ca_valid, ca_req);
		if (ca_req) begin
			check("ca slots", lnk.dl_ca_ts, ca_com ? 4'h0 : ca_ts);
			check("ca type", lnk.dl_ca_type, ca_type);
		end
		grant = 1'b0;
		wt = 1'b0;
		ca_req = 1'b0;
		step(3);
	endtask

	// ****
	// Scenarios
	// ****
	task t_alloc;
		int r0;
		b_addr = STN;
		for (int i = 0; i < 4; i++) begin
			r0 = rej_n;
			ca_req = 1'b1;
			ca_type = mrf_alloc_type'(i);
			ca_ts = 4'(1 << i);
			ca_carr = 12'h100 + 12'(i);
			ca_cell = (i == 2);
			pulse_send(i[0]);
			check("add reject", rej_n - r0, i == 1);
			check("slots", ch_ts, (i == 1) ? 4'h1 : 4'(1 << i));
			check("carrier", ch_carr, (i == 1) ? 12'h100 : ca_carr);
			check("cell", ch_cell, i == 2);
		end
		ca_req = 1'b1;
		ca_type = MRF_AT_REPLACE;
		ca_com = 1'b1;
		ca_carr = 12'h0a5;
		pulse_send(1'b0);
		ca_com = 1'b0;
		check("common", ch_com, 1'b1);
		check("main carrier", ch_carr, 12'h0a5);
		conc_ok = 1'b1;
		ca_req = 1'b1;
		ca_type = MRF_AT_ADD;
		ca_ts = 4'h3;
		pulse_send(1'b0);
		check("concurrent add", ch_ts, 4'h3);
		conc_ok = 1'b0;
		acc_add = 1'b1;
		ca_req = 1'b1;
		ca_type = MRF_AT_ADD;
		ca_ts = 4'h6;
		pulse_send(1'b1);
		check("moved", ch_ts, 4'h6);
		b_addr = 24'h00ffee;
		ca_req = 1'b1;
		ca_type = MRF_AT_REPLACE;
		ca_ts = 4'h9;
		pulse_send(1'b0);
		check("other station", ch_ts, 4'h6);
		b_addr = STN;
		$display("test alloc done");
	endtask

	task t_fallback;
		int n0;
		n0 = ul_n;
		buf_q = 1'b1;
		more_q = 1'b1;
		pulse_res();
		opps(EFF - 1);
		check("early access", ul_n - n0, 1);
		check("expiry low", rev_exp, 1'b0);
		opps(1);
		check("access count", ul_n - n0, 2);
		check("access kind", ul_k, MRF_PDU_ACCESS);
		check("access need", ul_r, 1'b1);
		check("access sdu", ul_s, 1'b1);
		check("access addr", lnk.ul_addr, STN);
		check("base need", seen_r, 1'b1);
		check("base count", seen_n, ul_n);
		more_q = 1'b0;
		opps(EFF);
		check("retry need", ul_r, 1'b0);
		do_cancel(8'h5b, 0, MRF_RPT_NONE);
		do_cancel(REQ_H, 1, MRF_RPT_SENT);
		opps(2 * EFF);
		check("no retry", ul_n - n0, 3);
		$display("test fallback done");
	endtask

	task t_wait_grant;
		int n0;
		n0 = ul_n;
		more_q = 1'b1;
		pulse_res();
		opps(3);
		grant = 1'b1;
		wt = 1'b1;
		pulse_send(1'b0);
		opps(EFF - 1);
		check("restarted", ul_n - n0, 1);
		opps(1);
		check("access late", ul_n - n0, 2);
		do_cancel(REQ_H, 1, MRF_RPT_SENT);
		$display("test wait grant done");
	endtask

	// Either capacity held or buffer empty: the timer runs out, no access;
	// an empty buffer drops the request, leaving nothing to cancel
	task t_hold(input logic gr, input logic bf);
		int n0;
		n0 = ul_n;
		buf_q = bf;
		pulse_res();
		grant = gr;
		pulse_send(1'b0);
		opps(EFF + 2);
		check("held access", ul_n - n0, 1);
		check("expiry shown", rev_exp, bf);
		do_cancel(REQ_H, bf, MRF_RPT_PARTIAL);
		$display("test hold done");
	endtask

	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Run is some 330 cycles; the watchdog allows several times that
	initial begin
		#100000;
		err_count++;
		print_verdict();
	end

	initial begin
		{rst_b, buf_q, more_q, send_res, cancel, conc_ok, acc_add} = '0;
		{opp, send, frag, grant, wt, ca_req, ca_com, ca_cell} = '0;
		{cancel_h, b_addr, ca_ts, ca_carr} = '0;
		ca_type = MRF_AT_REPLACE;
		repeat (6) @(posedge clk);
		#1;
		rst_b = 1'b1;
		step(1);
		t_alloc();
		t_fallback();
		t_wait_grant();
		t_hold(1'b1, 1'b1);
		t_hold(1'b0, 1'b0);
		print_verdict();
	end
endmodule
`default_nettype wire
